//--- src/ret_rot_pkg.sv
package ret_rot_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR    = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_ACC      = 8'h08;
  localparam logic [7:0] ADDR_FLAGS    = 8'h0C;
  localparam logic [7:0] ADDR_BANK     = 8'h10;
  localparam logic [7:0] ADDR_SH_ACC   = 8'h14;
  localparam logic [7:0] ADDR_SH_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_SH_BANK  = 8'h1C;
  localparam logic [7:0] ADDR_PC       = 8'h20;
  localparam logic [7:0] ADDR_STACK    = 8'h24;
  localparam logic [7:0] ADDR_UPPER    = 8'h28;
  localparam logic [7:0] ADDR_HIGH     = 8'h2C;
  localparam logic [7:0] ADDR_FADDR    = 8'h30;
  localparam logic [7:0] ADDR_FDATA    = 8'h34;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_C       = 0;
  localparam int unsigned FLAG_Z       = 2;
  localparam int unsigned FLAG_N       = 4;
  localparam int unsigned BIT_FAST     = 0;
  localparam int unsigned BIT_ACCESS   = 8;
  localparam int unsigned BIT_DEST     = 9;
  localparam int unsigned STAT_PENDING = 0;
  localparam int unsigned STAT_BUSY    = 1;
  localparam int unsigned STAT_SP_LSB  = 8;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [14:0] OPC_RETURN = 15'h0009;
  localparam logic [5:0]  OPC_RLC    = 6'h0D;
  localparam logic [5:0]  OPC_RRC    = 6'h0C;
  localparam logic [5:0]  OPC_RLN    = 6'h11;
  localparam logic [5:0]  OPC_RRN    = 6'h10;
  localparam logic [7:0]  FLAGS_MASK = 8'h1F;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_INSTR  = 16'h0000;

  // ---------------------------------------------------------------
  // Timing: four phases per instruction cycle
  // ---------------------------------------------------------------
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q3 = 2'h2;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RET2 = 2'b10
  } exec_state_t;

endpackage : ret_rot_pkg

//--- src/file_port_if.sv
`timescale 1ns/1ps
`default_nettype none

// Ports of the banked file register memory.
interface file_port_if #(parameter int unsigned AW = 12);
  logic [AW-1:0] ex_addr;
  logic [7:0]    ex_rdata;
  logic [AW-1:0] sw_addr;
  logic [7:0]    sw_rdata;
  logic          we;
  logic [AW-1:0] waddr;
  logic [7:0]    wdata;

  modport ctrl (output ex_addr, sw_addr, we, waddr, wdata, input ex_rdata, sw_rdata);
  modport mem  (input ex_addr, sw_addr, we, waddr, wdata, output ex_rdata, sw_rdata);
endinterface : file_port_if

`default_nettype wire

//--- src/file_ram.sv
`timescale 1ns/1ps
`default_nettype none

module file_ram #(
  parameter int unsigned AW = 12
) (
  // Clock.
  input wire logic  ref_clk_i,
  // Memory ports.
  file_port_if.mem  fp
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] mem_q [2**AW];

  // Write port; data memory content is not reset, as in a real core.
  always_ff @(posedge ref_clk_i) begin
    if (fp.we) begin
      mem_q[fp.waddr] <= fp.wdata;
    end
  end

  // Asynchronous reads let the operand be sampled within one phase.
  assign fp.ex_rdata = mem_q[fp.ex_addr];
  assign fp.sw_rdata = mem_q[fp.sw_addr];

endmodule : file_ram

`default_nettype wire

//--- src/ret_rot_exec.sv
// Functional notes
// (RULE1) Return pops the stack and loads the popped top entry into the PC.
// (RULE2) Fast bit set restores accumulator, flags, bank from shadows; clear leaves them.
// (RULE3) Return is one word, two cycles; pop in last phase of first cycle.
// (RULE4) Return leaves the upper and high PC latches unchanged.
// (RULE5) Return alters no flags except the shadow reload under fast restore.
// (RULE6) Rotate left through carry: bit n to n+1, bit7 to carry, carry to bit0.
// (RULE7) Rotate right through carry: bit n to n-1, bit0 to carry, carry to bit7.
// (RULE8) Rotate left no carry: bit7 wraps to bit0, carry untouched.
// (RULE9) Rotate right no carry: bit0 wraps to bit7, carry untouched.
// (RULE10) Through-carry rotates update carry, negative and zero flags.
// (RULE11) No-carry rotates update only negative and zero flags.
// (RULE12) Destination bit 0 writes accumulator, 1 writes back the file register.
// (RULE13) Access bit 0 uses the fixed access bank, 1 the selected bank.
// (RULE14) Rotate is one cycle: decode, read, compute, write in four phases.
// (RULE15) Negative equals result bit 7; zero set exactly when result is zero.
`timescale 1ns/1ps
`default_nettype none

module ret_rot_exec #(
  parameter int unsigned BANK_W      = 4,
  parameter int unsigned PC_W        = 21,
  parameter int unsigned STACK_DEPTH = 31
) (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int unsigned AW  = BANK_W + 8;
  localparam int unsigned SPW = $clog2(STACK_DEPTH + 1);
  localparam logic [BANK_W-1:0] ACCESS_BANK = '0;

  ret_rot_pkg::exec_state_t state_q;
  logic [1:0]      phase_q;
  logic            pending_q;
  logic [15:0]     instr_q;
  logic [15:0]     cur_q;
  logic [AW-1:0]   addr_q;
  logic [7:0]      operand_q;
  logic [7:0]      result_q;
  logic [7:0]      flags_new_q;
  logic [7:0]      acc_q;
  logic [7:0]      flags_q;
  logic [BANK_W-1:0] bank_q;
  logic [7:0]      sh_acc_q;
  logic [7:0]      sh_flags_q;
  logic [BANK_W-1:0] sh_bank_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0]      upper_q;
  logic [7:0]      high_q;
  logic [AW-1:0]   faddr_q;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [SPW-1:0]  sp_q;
  logic [PC_W-1:0] stack_top;
  logic            busy;
  logic            is_ret, is_rlc, is_rrc, is_rln, is_rrn, is_rot;
  logic            q4, ret_fire, rot_fire;
  logic            setup, wr_fire, wr_err;
  logic [31:0]     rd_mux;

  file_port_if #(.AW(AW)) fp ();

  file_ram #(.AW(AW)) u_ram (
    .ref_clk_i (ref_clk_i),
    .fp        (fp.mem)
  );

  // ---------------------------------------------------------------
  // Decode of the instruction in execution
  // ---------------------------------------------------------------
  // Checks whether a word belongs to this instruction group.
  function automatic logic op_valid(input logic [15:0] w);
    op_valid = (w[15:1] == ret_rot_pkg::OPC_RETURN) ||
               (w[15:10] == ret_rot_pkg::OPC_RLC) || (w[15:10] == ret_rot_pkg::OPC_RRC) ||
               (w[15:10] == ret_rot_pkg::OPC_RLN) || (w[15:10] == ret_rot_pkg::OPC_RRN);
  endfunction : op_valid

  // Opcode field compares on the current instruction.
  assign is_ret   = cur_q[15:1] == ret_rot_pkg::OPC_RETURN;
  assign is_rlc   = cur_q[15:10] == ret_rot_pkg::OPC_RLC;
  assign is_rrc   = cur_q[15:10] == ret_rot_pkg::OPC_RRC;
  assign is_rln   = cur_q[15:10] == ret_rot_pkg::OPC_RLN;
  assign is_rrn   = cur_q[15:10] == ret_rot_pkg::OPC_RRN;
  assign is_rot   = is_rlc | is_rrc | is_rln | is_rrn;
  assign q4       = (state_q == ret_rot_pkg::ST_EXEC) && (phase_q == ret_rot_pkg::PHASE_Q4);
  assign ret_fire = q4 && is_ret;
  assign rot_fire = q4 && is_rot;
  assign busy     = pending_q || (state_q != ret_rot_pkg::ST_IDLE);

  // Top entry of the return stack; an empty stack reads as zero.
  assign stack_top = (sp_q == '0) ? '0 : stack_q[SPW'(sp_q - 1'b1)];

  // ---------------------------------------------------------------
  // Phase divider and sequencer
  // ---------------------------------------------------------------
  // Free-running phase count; each value is one quarter of a cycle.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase_q <= ret_rot_pkg::PHASE_Q1;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Instruction cycles advance at the end of the last phase.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ret_rot_pkg::ST_IDLE;
    end else if (phase_q == ret_rot_pkg::PHASE_Q4) begin
      case (state_q)
        ret_rot_pkg::ST_IDLE: begin
          if (pending_q) state_q <= ret_rot_pkg::ST_EXEC;
        end
        ret_rot_pkg::ST_EXEC: begin
          if (is_ret) state_q <= ret_rot_pkg::ST_RET2;  // [RULE3]
          else if (!pending_q) state_q <= ret_rot_pkg::ST_IDLE;
        end
        ret_rot_pkg::ST_RET2: begin
          state_q <= pending_q ? ret_rot_pkg::ST_EXEC : ret_rot_pkg::ST_IDLE;
        end
        default: state_q <= ret_rot_pkg::ST_IDLE;
      endcase
    end
  end

  // Issue slot; software writes are refused while it is full, so no clear can race a set.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pending_q <= 1'b0;
      instr_q   <= ret_rot_pkg::RST_INSTR;
    end else if (wr_fire && paddr_i == ret_rot_pkg::ADDR_INSTR) begin
      pending_q <= 1'b1;
      instr_q   <= pwdata_i[15:0];
    end else if (phase_q == ret_rot_pkg::PHASE_Q4 && pending_q &&
                 !(state_q == ret_rot_pkg::ST_EXEC && is_ret)) begin
      pending_q <= 1'b0;
    end
  end

  // Current instruction is taken when the slot is consumed.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cur_q <= ret_rot_pkg::RST_INSTR;
    end else if (phase_q == ret_rot_pkg::PHASE_Q4 && pending_q &&
                 !(state_q == ret_rot_pkg::ST_EXEC && is_ret)) begin
      cur_q <= instr_q;
    end
  end

  // ---------------------------------------------------------------
  // Rotate datapath
  // ---------------------------------------------------------------
  // Q1 decode forms the file address, Q2 reads, Q3 computes.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_q      <= '0;
      operand_q   <= ret_rot_pkg::RST_BYTE;
      result_q    <= ret_rot_pkg::RST_BYTE;
      flags_new_q <= ret_rot_pkg::RST_BYTE;
    end else if (state_q == ret_rot_pkg::ST_EXEC && is_rot) begin
      case (phase_q)
        ret_rot_pkg::PHASE_Q1: begin
          addr_q <= {cur_q[ret_rot_pkg::BIT_ACCESS] ? bank_q : ACCESS_BANK, cur_q[7:0]};  // [RULE13] [RULE14]
        end
        ret_rot_pkg::PHASE_Q2: begin
          operand_q <= fp.ex_rdata;  // [RULE14]
        end
        ret_rot_pkg::PHASE_Q3: begin
          flags_new_q <= flags_q;
          if (is_rlc) begin
            result_q <= {operand_q[6:0], flags_q[ret_rot_pkg::FLAG_C]};  // [RULE6]
            flags_new_q[ret_rot_pkg::FLAG_C] <= operand_q[7];  // [RULE10]
            flags_new_q[ret_rot_pkg::FLAG_N] <= operand_q[6];  // [RULE15]
            flags_new_q[ret_rot_pkg::FLAG_Z] <= {operand_q[6:0], flags_q[ret_rot_pkg::FLAG_C]} == 8'h00;
          end else if (is_rrc) begin
            result_q <= {flags_q[ret_rot_pkg::FLAG_C], operand_q[7:1]};  // [RULE7]
            flags_new_q[ret_rot_pkg::FLAG_C] <= operand_q[0];  // [RULE10]
            flags_new_q[ret_rot_pkg::FLAG_N] <= flags_q[ret_rot_pkg::FLAG_C];  // [RULE15]
            flags_new_q[ret_rot_pkg::FLAG_Z] <= {flags_q[ret_rot_pkg::FLAG_C], operand_q[7:1]} == 8'h00;
          end else if (is_rln) begin
            result_q <= {operand_q[6:0], operand_q[7]};  // [RULE8]
            flags_new_q[ret_rot_pkg::FLAG_N] <= operand_q[6];  // [RULE11] [RULE15]
            flags_new_q[ret_rot_pkg::FLAG_Z] <= operand_q == 8'h00;
          end else begin
            result_q <= {operand_q[0], operand_q[7:1]};  // [RULE9]
            flags_new_q[ret_rot_pkg::FLAG_N] <= operand_q[0];  // [RULE11] [RULE15]
            flags_new_q[ret_rot_pkg::FLAG_Z] <= operand_q == 8'h00;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Memory ports: the core owns the write port during Q4 of a rotate.
  assign fp.ex_addr = addr_q;
  assign fp.sw_addr = faddr_q;
  assign fp.we      = (rot_fire && cur_q[ret_rot_pkg::BIT_DEST]) ||  // [RULE12]
                      (wr_fire && paddr_i == ret_rot_pkg::ADDR_FDATA);
  assign fp.waddr   = rot_fire ? addr_q : faddr_q;
  assign fp.wdata   = rot_fire ? result_q : pwdata_i[7:0];

  // ---------------------------------------------------------------
  // Architectural registers
  // ---------------------------------------------------------------
  // Accumulator: shadow reload, rotate result or software write.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      acc_q <= ret_rot_pkg::RST_BYTE;
    end else if (ret_fire && cur_q[ret_rot_pkg::BIT_FAST]) begin
      acc_q <= sh_acc_q;  // [RULE2]
    end else if (rot_fire && !cur_q[ret_rot_pkg::BIT_DEST]) begin
      acc_q <= result_q;  // [RULE12]
    end else if (wr_fire && paddr_i == ret_rot_pkg::ADDR_ACC) begin
      acc_q <= pwdata_i[7:0];
    end
  end

  // Status flags; a plain return leaves them as they are.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags_q <= ret_rot_pkg::RST_BYTE;
    end else if (ret_fire && cur_q[ret_rot_pkg::BIT_FAST]) begin
      flags_q <= sh_flags_q;  // [RULE2] [RULE5]
    end else if (rot_fire) begin
      flags_q <= flags_new_q;  // [RULE10] [RULE11]
    end else if (wr_fire && paddr_i == ret_rot_pkg::ADDR_FLAGS) begin
      flags_q <= pwdata_i[7:0] & ret_rot_pkg::FLAGS_MASK;
    end
  end

  // Bank select.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bank_q <= '0;
    end else if (ret_fire && cur_q[ret_rot_pkg::BIT_FAST]) begin
      bank_q <= sh_bank_q;  // [RULE2]
    end else if (wr_fire && paddr_i == ret_rot_pkg::ADDR_BANK) begin
      bank_q <= pwdata_i[BANK_W-1:0];
    end
  end

  // Shadows, PC latches and file address are software loaded only.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sh_acc_q   <= ret_rot_pkg::RST_BYTE;
      sh_flags_q <= ret_rot_pkg::RST_BYTE;
      sh_bank_q  <= '0;
      upper_q    <= ret_rot_pkg::RST_BYTE;
      high_q     <= ret_rot_pkg::RST_BYTE;
      faddr_q    <= '0;
    end else if (wr_fire) begin
      case (paddr_i)
        ret_rot_pkg::ADDR_SH_ACC:   sh_acc_q   <= pwdata_i[7:0];
        ret_rot_pkg::ADDR_SH_FLAGS: sh_flags_q <= pwdata_i[7:0] & ret_rot_pkg::FLAGS_MASK;
        ret_rot_pkg::ADDR_SH_BANK:  sh_bank_q  <= pwdata_i[BANK_W-1:0];
        ret_rot_pkg::ADDR_UPPER:    upper_q    <= pwdata_i[7:0];  // [RULE4]
        ret_rot_pkg::ADDR_HIGH:     high_q     <= pwdata_i[7:0];
        ret_rot_pkg::ADDR_FADDR:    faddr_q    <= pwdata_i[AW-1:0];
        default: begin
        end
      endcase
    end
  end

  // Program counter takes the popped entry at the end of the first cycle.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_q <= '0;
    end else if (ret_fire) begin
      pc_q <= stack_top;  // [RULE1] [RULE3]
    end else if (wr_fire && paddr_i == ret_rot_pkg::ADDR_PC) begin
      pc_q <= pwdata_i[PC_W-1:0];
    end
  end

  // Stack pointer; popping an empty stack keeps it at zero.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sp_q <= '0;
    end else if (ret_fire && sp_q != '0) begin
      sp_q <= sp_q - 1'b1;  // [RULE1]
    end else if (wr_fire && paddr_i == ret_rot_pkg::ADDR_STACK) begin
      sp_q <= sp_q + 1'b1;
    end
  end

  // Stack entries hold no reset; only entries below the pointer are read.
  always_ff @(posedge ref_clk_i) begin
    if (wr_fire && paddr_i == ret_rot_pkg::ADDR_STACK) begin
      stack_q[sp_q] <= pwdata_i[PC_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Everything is decided in the setup cycle, so each access has one wait-free access phase.
  assign setup   = psel_i && !penable_i;
  assign wr_fire = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

  // Writes are refused while busy, so software never races the core for a register.
  always_comb begin
    wr_err = 1'b0;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      ret_rot_pkg::ADDR_INSTR: begin
        rd_mux = {16'h0000, instr_q};
        wr_err = !op_valid(pwdata_i[15:0]);
      end
      ret_rot_pkg::ADDR_STATUS: begin
        rd_mux[ret_rot_pkg::STAT_PENDING] = pending_q;
        rd_mux[ret_rot_pkg::STAT_BUSY]    = state_q != ret_rot_pkg::ST_IDLE;
        rd_mux[ret_rot_pkg::STAT_SP_LSB +: SPW] = sp_q;
        wr_err = 1'b1;
      end
      ret_rot_pkg::ADDR_ACC:      rd_mux[7:0] = acc_q;
      ret_rot_pkg::ADDR_FLAGS:    rd_mux[7:0] = flags_q;
      ret_rot_pkg::ADDR_BANK:     rd_mux[BANK_W-1:0] = bank_q;
      ret_rot_pkg::ADDR_SH_ACC:   rd_mux[7:0] = sh_acc_q;
      ret_rot_pkg::ADDR_SH_FLAGS: rd_mux[7:0] = sh_flags_q;
      ret_rot_pkg::ADDR_SH_BANK:  rd_mux[BANK_W-1:0] = sh_bank_q;
      ret_rot_pkg::ADDR_PC:       rd_mux[PC_W-1:0] = pc_q;
      ret_rot_pkg::ADDR_STACK: begin
        rd_mux[PC_W-1:0] = stack_top;
        wr_err = sp_q == SPW'(STACK_DEPTH);
      end
      ret_rot_pkg::ADDR_UPPER:    rd_mux[7:0] = upper_q;
      ret_rot_pkg::ADDR_HIGH:     rd_mux[7:0] = high_q;
      ret_rot_pkg::ADDR_FADDR:    rd_mux[AW-1:0] = faddr_q;
      ret_rot_pkg::ADDR_FDATA:    rd_mux[7:0] = fp.sw_rdata;
      default: begin
        wr_err = 1'b1;
      end
    endcase
    if (!pwrite_i) begin
      wr_err = (paddr_i[1:0] != 2'h0) || (paddr_i > ret_rot_pkg::ADDR_FDATA);
    end else if (busy) begin
      wr_err = 1'b1;
    end
  end

  // Answer registers.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (setup) begin
      pready_o  <= 1'b1;
      pslverr_o <= wr_err;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_ret_pop: assert property ((ret_fire && sp_q != '0) |=> pc_q == $past(stack_top) && sp_q == $past(sp_q) - 1'b1) else $error("return did not pop the stack into pc");  // [RULE1]
  a_fast_restore: assert property ((ret_fire && cur_q[0]) |=> acc_q == $past(sh_acc_q) && bank_q == $past(sh_bank_q) && flags_q == $past(sh_flags_q)) else $error("fast restore missed a shadow");  // [RULE2]
  a_ret_two_cycles: assert property (ret_fire |=> (state_q == ret_rot_pkg::ST_RET2)[*4] ##1 (state_q != ret_rot_pkg::ST_RET2)) else $error("return second cycle length wrong");  // [RULE3]
  a_ret_latches: assert property (ret_fire |=> $stable(upper_q) && $stable(high_q)) else $error("return changed a pc latch");  // [RULE4]
  a_ret_plain: assert property ((ret_fire && !cur_q[0]) |=> $stable(flags_q) && $stable(acc_q) && $stable(bank_q)) else $error("plain return changed context");  // [RULE5]
  a_rlc_result: assert property ((rot_fire && is_rlc) |-> result_q == {operand_q[6:0], flags_q[0]} && flags_new_q[0] == operand_q[7]) else $error("left carry rotate wrong");  // [RULE6]
  a_rrc_result: assert property ((rot_fire && is_rrc) |-> result_q == {flags_q[0], operand_q[7:1]} && flags_new_q[0] == operand_q[0]) else $error("right carry rotate wrong");  // [RULE7]
  a_rln_result: assert property ((rot_fire && is_rln) |-> result_q == {operand_q[6:0], operand_q[7]}) else $error("left rotate wrong");  // [RULE8]
  a_rrn_result: assert property ((rot_fire && is_rrn) |-> result_q == {operand_q[0], operand_q[7:1]}) else $error("right rotate wrong");  // [RULE9]
  a_carry_update: assert property ((rot_fire && (is_rlc || is_rrc)) |=> flags_q[0] == $past(flags_new_q[0]) && $past(flags_new_q[0]) == ($past(is_rlc) ? $past(operand_q[7]) : $past(operand_q[0]))) else $error("carry not updated");  // [RULE10]
  a_carry_kept: assert property ((rot_fire && (is_rln || is_rrn)) |=> flags_q == ($past(flags_q) & 8'hEB | $past(flags_new_q) & 8'h14)) else $error("no-carry rotate touched other flags");  // [RULE11]
  a_dest_select: assert property (rot_fire |-> fp.we == cur_q[9]) else $error("rotate destination wrong");  // [RULE12]
  a_dest_acc: assert property ((rot_fire && !cur_q[9]) |=> acc_q == $past(result_q)) else $error("rotate result missed the accumulator");  // [RULE12]
  a_access_bank: assert property ((state_q == ret_rot_pkg::ST_EXEC && is_rot && phase_q == 2'h0) |=> addr_q == {$past(cur_q[8]) ? $past(bank_q) : ACCESS_BANK, $past(cur_q[7:0])}) else $error("bank selection wrong");  // [RULE13]
  a_rot_one_cycle: assert property ((state_q == ret_rot_pkg::ST_EXEC && is_rot && phase_q == 2'h0) |-> ##3 rot_fire) else $error("rotate not written in fourth phase");  // [RULE14]
  a_nz_flags: assert property (rot_fire |=> flags_q[4] == $past(result_q[7]) && flags_q[2] == ($past(result_q) == 8'h00)) else $error("negative or zero flag wrong");  // [RULE15]

endmodule : ret_rot_exec

`default_nettype wire

//--- test/ret_rot_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ret_rot_exec_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, v, r, fl;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, c, nc, d, a;
  logic [5:0]  op;
  int          fail_count = 0;
  int          checks = 0;

  // The clock runs at 125 MHz.
  always #4 clk = ~clk;

  ret_rot_exec DUT (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One comparison; a mismatch is reported at once.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; the idle edge at the end keeps two calls out of one time step.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Transfer with the expected error flag and, on reads, the expected data.
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] dv, input logic ee);
    apb(w, ad, dv);
    if (!w) chk($sformatf("data at %h", ad), rdat, dv);
    chk($sformatf("error at %h", ad), {31'h0, rerr}, {31'h0, ee});
  endtask : xfer

  // Polls status until nothing is pending or executing; bounded so a hang cannot stall it.
  task automatic idle();
    int n;
    n = 0;
    do begin apb(1'b0, ret_rot_pkg::ADDR_STATUS, 32'h0); n++; end while (rdat[1:0] !== 2'b00 && n < 40);
    chk("busy bits", {30'h0, rdat[1:0]}, 32'h0);
  endtask : idle

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // Watchdog: the whole sequence needs well under 25000 cycles.
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Every rotate with every destination and access choice; the first four start from a zero operand.
    // The operand sits only in the bank the access bit picks; the other bank holds its inverse.
    for (int i = 0; i < 16; i++) begin
      v = (i < 4) ? 8'h00 : 8'hE6 + 8'(i);
      c = i[0] ^ i[2];
      a = i[2];
      d = i[3];
      case (i % 4)
        0: begin op = ret_rot_pkg::OPC_RLC; r = {v[6:0], c}; nc = v[7]; end
        1: begin op = ret_rot_pkg::OPC_RRC; r = {c, v[7:1]}; nc = v[0]; end
        2: begin op = ret_rot_pkg::OPC_RLN; r = {v[6:0], v[7]}; nc = c; end
        default: begin op = ret_rot_pkg::OPC_RRN; r = {v[0], v[7:1]}; nc = c; end
      endcase
      fl = {3'h0, r[7], 1'b1, r == 8'h00, 1'b1, nc};
      xfer(1'b1, ret_rot_pkg::ADDR_BANK, 32'h3, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_FADDR, a ? 32'h345 : 32'h045, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_FDATA, {24'h0, v}, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_FADDR, a ? 32'h045 : 32'h345, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_FDATA, {24'h0, ~v}, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_ACC, 32'h5A, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_FLAGS, {28'h0, 4'hA | {3'h0, c}}, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_INSTR, {16'h0, op, d, a, 8'h45}, 1'b0);
      idle();
      xfer(1'b0, ret_rot_pkg::ADDR_ACC, d ? 32'h5A : {24'h0, r}, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_FADDR, a ? 32'h345 : 32'h045, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_FDATA, {24'h0, d ? r : v}, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_FADDR, a ? 32'h045 : 32'h345, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_FDATA, {24'h0, ~v}, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_FLAGS, {24'h0, fl}, 1'b0);
    end
    // Returns without and with fast restore; a write while busy must be refused.
    for (int s = 0; s < 2; s++) begin
      xfer(1'b1, ret_rot_pkg::ADDR_STACK, 32'h012345, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_STACK, 32'h1ABCDE, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_SH_ACC, 32'h3C, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_SH_FLAGS, 32'h15, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_SH_BANK, 32'h7, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_FLAGS, 32'h0A, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_UPPER, 32'h11, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_HIGH, 32'h22, 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_INSTR, 32'h0012 | 32'(s), 1'b0);
      xfer(1'b1, ret_rot_pkg::ADDR_ACC, 32'hFF, 1'b1);
      idle();
      xfer(1'b0, ret_rot_pkg::ADDR_PC, 32'h1ABCDE, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_STACK, 32'h012345, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_STATUS, 32'(s + 1) << 8, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_ACC, s ? 32'h3C : 32'h5A, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_FLAGS, s ? 32'h15 : 32'h0A, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_BANK, s ? 32'h7 : 32'h3, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_UPPER, 32'h11, 1'b0);
      xfer(1'b0, ret_rot_pkg::ADDR_HIGH, 32'h22, 1'b0);
    end
    // Refused accesses: read-only status, unknown instruction, unmapped address.
    xfer(1'b1, ret_rot_pkg::ADDR_STATUS, 32'h1, 1'b1);
    xfer(1'b1, ret_rot_pkg::ADDR_INSTR, 32'h0000, 1'b1);
    xfer(1'b0, 8'h3C, 32'h0, 1'b1);
    finish_test();
  end
endmodule : ret_rot_exec_bench

`default_nettype wire
